/* File: rft_pkg.sv */
package rft_pkg;

  // ---------------------------------------------------------------
  // Memory and configuration layout
  // ---------------------------------------------------------------
  localparam int MEM_BITS   = 128;
  localparam int CFG_BITS   = 12;
  localparam int LOCK_POS   = 11;   // config_lock_bit
  localparam int RATE_HI    = 1;    // Rate select, first code bit
  localparam int RATE_MID   = 2;
  localparam int RATE_LO    = 3;
  localparam int CODE_HI    = 5;    // Coding select
  localparam int CODE_LO    = 6;
  localparam int MODK_HI    = 7;    // Modulation kind
  localparam int MODK_LO    = 8;

  // ---------------------------------------------------------------
  // Timing in carrier cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] RATE_DIV_128 = 8'h80;
  localparam logic [7:0] RATE_DIV_100 = 8'h64;
  localparam logic [7:0] RATE_DIV_80  = 8'h50;
  localparam logic [7:0] RATE_DIV_64  = 8'h40;
  localparam logic [7:0] RATE_DIV_50  = 8'h32;
  localparam logic [7:0] RATE_DIV_40  = 8'h28;
  localparam logic [7:0] RATE_DIV_32  = 8'h20;
  localparam logic [7:0] RATE_DIV_16  = 8'h10;
  localparam logic [7:0] PROG_LAST    = 8'h7F;  // Last cycle of a programming bit
  localparam logic [7:0] PROG_SAMPLE  = 8'h40;  // Mid-bit amplitude sample
  localparam logic [7:0] ONE_8        = 8'h01;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RFT_POWER  = 3'b000,
    RFT_GAP    = 3'b001,
    RFT_VERIFY = 3'b010,
    RFT_PROG   = 3'b011,
    RFT_RESP   = 3'b100,
    RFT_DONE   = 3'b101,
    RFT_READ   = 3'b110
  } rft_state_t;

  typedef enum logic [1:0] {
    RFT_NRZ    = 2'b00,
    RFT_DIFF   = 2'b01,
    RFT_MAN    = 2'b10,
    RFT_MANINV = 2'b11
  } rft_code_t;

  typedef struct packed {
    logic       data;
    logic [7:0] div;
    rft_code_t  code;
  } rft_sym_t;

endpackage : rft_pkg

/* File: rft_reader.sv */
module rft_reader
  import rft_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nvm_wr_en,
  input  wire logic [MEM_BITS-1:0] nvm_wr_data,
  input  wire logic                nvm_lock_set,
  output logic                     field_present,
  output logic                     field_high,
  output logic [MEM_BITS-1:0]      nvm_data,
  output logic [CFG_BITS-1:0]      nvm_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Field and memory cells
  // ----------------------------------------
  // Field on at normal level; blank cells read all ones
  initial begin
    field_present = 1'b1;
    field_high = 1'b0;
    nvm_data = {MEM_BITS{1'b1}};
    nvm_cfg = 12'h000;
  end
  // Cells are outside the tag, so writes and lock survive its reset
  always @(posedge sys_clk) begin
    if (nvm_wr_en) nvm_data <= nvm_wr_data;
    if (nvm_lock_set) nvm_cfg[LOCK_POS] <= 1'b1;
  end
  // Short field gap after power-up
  task automatic gap();
    @(posedge sys_clk);
    field_present <= 1'b0;
    repeat (64) @(posedge sys_clk);
    field_present <= 1'b1;
  endtask
  // Verify phase, then bits with no pause; mid-bit sampling tolerates small skew
  task automatic send_bits(input logic [MEM_BITS-1:0] bits);
    gap();
    repeat (128 * 128) @(posedge sys_clk);
    for (int k = 0; k < MEM_BITS; k++) begin
      field_high <= ~bits[k];
      repeat (128) @(posedge sys_clk);
    end
    field_high <= 1'b0;
  endtask
  task automatic drop();
    @(posedge sys_clk);
    field_present <= 1'b0;
  endtask
endmodule // rft_reader

/* File: rft_tag.sv */
module rft_tag
  import rft_pkg::*;
#(
  parameter int MEM_W = MEM_BITS
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                field_present,
  input  wire logic                field_high,
  input  wire logic [MEM_W-1:0]    nvm_data,
  input  wire logic [CFG_BITS-1:0] nvm_cfg,
  output logic                     mod_out,
  output logic [1:0]               mod_kind,
  output logic                     nvm_wr_en,
  output logic [MEM_W-1:0]         nvm_wr_data,
  output logic                     nvm_lock_set,
  output rft_state_t               tag_mode
);

  localparam int IW = $clog2(MEM_W);
  localparam logic [IW-1:0] IDX_LAST = IW'(MEM_W - 1);

  // ---------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------
  function automatic logic [7:0] rate_div(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_div = RATE_DIV_128;
      3'h1:    rate_div = RATE_DIV_100;
      3'h2:    rate_div = RATE_DIV_80;
      3'h3:    rate_div = RATE_DIV_32;
      3'h4:    rate_div = RATE_DIV_64;
      3'h5:    rate_div = RATE_DIV_50;
      3'h6:    rate_div = RATE_DIV_40;
      default: rate_div = RATE_DIV_16;
    endcase
  endfunction

  function automatic logic locked(input logic [CFG_BITS-1:0] cfg);
    locked = cfg[LOCK_POS];
  endfunction

  // ---------------------------------------------------------------
  // Symbol source
  // ---------------------------------------------------------------
  logic [IW-1:0] src_idx;
  logic          src_all;   // Whole frame pushed
  logic          src_valid;
  rft_sym_t      src_sym;
  logic          buf_ready;
  logic          push;
  logic          drained;

  // Native format for a blank tag, configured format once locked
  always_comb begin
    src_sym.data = nvm_data[src_idx];
    src_sym.div  = RATE_DIV_128;
    src_sym.code = RFT_NRZ;
    src_valid    = 1'b0;
    case (tag_mode)
      RFT_POWER: begin
        src_valid = !locked(nvm_cfg);
      end
      RFT_VERIFY: begin
        src_sym.data = 1'b1;
        src_valid    = !src_all;
      end
      RFT_RESP: begin
        src_valid = !src_all && !nvm_wr_en;
      end
      RFT_READ: begin
        src_sym.div  = rate_div({nvm_cfg[RATE_HI], nvm_cfg[RATE_MID],
                                 nvm_cfg[RATE_LO]});
        src_sym.code = rft_code_t'({nvm_cfg[CODE_HI], nvm_cfg[CODE_LO]});
        src_valid    = 1'b1;
      end
      default: begin
        src_valid = 1'b0;
      end
    endcase
  end

  assign push = src_valid && buf_ready;

  // Frame index advances only on accepted pushes, so stalls lose nothing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      src_idx <= '0;
      src_all <= 1'b0;
    end else if (tag_mode == RFT_PROG || tag_mode == RFT_GAP) begin
      src_idx <= '0;
      src_all <= 1'b0;
    end else if (push) begin
      src_idx <= (src_idx == IDX_LAST) ? '0 : src_idx + IW'(1);
      src_all <= src_idx == IDX_LAST;
    end
  end

  // ---------------------------------------------------------------
  // Two-entry symbol buffer
  // ---------------------------------------------------------------
  rft_sym_t   buf_mem [2];
  logic       buf_wp;
  logic       buf_rp;
  logic [1:0] buf_cnt;
  logic       buf_valid;
  logic       pop;

  assign buf_ready = buf_cnt != 2'h2;
  assign buf_valid = buf_cnt != 2'h0;

  // Storage carries no reset; only the pointers and the count need one
  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem[buf_wp] <= src_sym;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else if (tag_mode == RFT_GAP) begin
      // No field means no supply, so queued bits are lost; verify starts clean
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      buf_wp  <= buf_wp ^ push;
      buf_rp  <= buf_rp ^ pop;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // ---------------------------------------------------------------
  // Bit encoder
  // ---------------------------------------------------------------
  rft_sym_t   enc_sym;
  logic       enc_busy;
  logic [7:0] enc_cnt;
  logic       enc_last;
  logic       enc_lvl;     // Differential biphase running level
  logic       next_mod;
  logic       second_half;

  assign enc_last    = enc_busy && (enc_cnt == enc_sym.div - ONE_8);
  assign pop         = buf_valid && (!enc_busy || enc_last);
  assign second_half = enc_cnt >= (enc_sym.div >> 1);
  assign drained     = src_all && !buf_valid && (!enc_busy || enc_last);

  // One symbol per div carrier cycles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enc_busy <= 1'b0;
      enc_cnt  <= 8'h00;
      enc_sym  <= '0;
    end else if (tag_mode == RFT_GAP) begin
      // A leftover bit would push verify and the programming slots late
      enc_busy <= 1'b0;
      enc_cnt  <= 8'h00;
    end else if (pop) begin
      enc_busy <= 1'b1;
      enc_cnt  <= 8'h00;
      enc_sym  <= buf_mem[buf_rp];
    end else if (enc_last) begin
      enc_busy <= 1'b0;
      enc_cnt  <= 8'h00;
    end else if (enc_busy) begin
      enc_cnt <= enc_cnt + ONE_8;
    end
  end

  // Biphase level flips at every bit edge, and mid-bit for a zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enc_lvl <= 1'b0;
    end else if (pop) begin
      enc_lvl <= ~enc_lvl;
    end else if (enc_busy && enc_cnt == (enc_sym.div >> 1) && !enc_sym.data) begin
      enc_lvl <= ~enc_lvl;
    end
  end

  always_comb begin
    case (enc_sym.code)
      RFT_NRZ:    next_mod = enc_sym.data;
      RFT_DIFF:   next_mod = enc_lvl;
      RFT_MAN:    next_mod = enc_sym.data ^ second_half;
      RFT_MANINV: next_mod = ~(enc_sym.data ^ second_half);
      default:    next_mod = 1'b0;
    endcase
  end

  // Registered pin drive; damps nothing while idle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mod_out  <= 1'b0;
      mod_kind <= 2'h0;
    end else begin
      mod_out  <= enc_busy && next_mod;
      mod_kind <= locked(nvm_cfg) ? {nvm_cfg[MODK_HI], nvm_cfg[MODK_LO]} : 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Programming receiver
  // ---------------------------------------------------------------
  logic [7:0]    prog_cnt;
  logic [IW-1:0] prog_idx;
  logic          prog_end;

  assign prog_end = tag_mode == RFT_PROG && prog_cnt == PROG_LAST && prog_idx == IDX_LAST;

  // One bit per 128 carrier cycles, sampled mid-bit
  always_ff @(posedge sys_clk) begin
    if (reset || tag_mode != RFT_PROG) begin
      prog_cnt <= 8'h00;
      prog_idx <= '0;
    end else begin
      prog_cnt <= (prog_cnt == PROG_LAST) ? 8'h00 : prog_cnt + ONE_8;
      if (prog_cnt == PROG_LAST) begin
        prog_idx <= prog_idx + IW'(1);
      end
    end
  end

  // Raised amplitude programs a zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_wr_data <= '1;
    end else if (tag_mode == RFT_PROG && prog_cnt == PROG_SAMPLE) begin
      nvm_wr_data[prog_idx] <= ~field_high;
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  // Reset is field power-up; a gap only matters on a blank tag
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tag_mode <= RFT_POWER;
    end else begin
      case (tag_mode)
        RFT_POWER: begin
          if (locked(nvm_cfg)) begin
            tag_mode <= RFT_READ;
          end else if (!field_present) begin
            tag_mode <= RFT_GAP;
          end
        end
        RFT_GAP: begin
          if (field_present) begin
            tag_mode <= RFT_VERIFY;
          end
        end
        RFT_VERIFY: begin
          if (drained) begin
            tag_mode <= RFT_PROG;
          end
        end
        RFT_PROG: begin
          if (!field_present) begin
            tag_mode <= RFT_DONE;
          end else if (prog_end) begin
            tag_mode <= RFT_RESP;
          end
        end
        RFT_RESP: begin
          if (!field_present) begin
            tag_mode <= RFT_DONE;
          end else if (drained) begin
            tag_mode <= RFT_PROG;
          end
        end
        RFT_DONE: begin
          tag_mode <= RFT_DONE;
        end
        RFT_READ: begin
          tag_mode <= RFT_READ;
        end
        default: begin
          tag_mode <= RFT_POWER;
        end
      endcase
    end
  end

  // Memory write after a full stream; lock pulse on field loss in RFT_PROG or RFT_RESP
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_wr_en    <= 1'b0;
      nvm_lock_set <= 1'b0;
    end else begin
      nvm_wr_en    <= prog_end && field_present;
      nvm_lock_set <= (tag_mode == RFT_PROG || tag_mode == RFT_RESP)
                      && !field_present;
    end
  end

endmodule // rft_tag

/* File: rft_tag_sva.sv */
module rft_chk
  import rft_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                reset,
  input wire logic                field_present,
  input wire logic [CFG_BITS-1:0] nvm_cfg,
  input wire logic [1:0]          mod_kind,
  input wire logic                nvm_wr_en,
  input wire logic                nvm_lock_set,
  input wire rft_state_t          tag_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_cnt;
  // Cycles in the present mode; restarts on a change so phase lengths are exact
  always_ff @(posedge sys_clk) begin
    if (reset || $changed(tag_mode)) begin
      run_cnt <= 16'h0000;
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Sequence and lock
  // ----------------------------------------
  blank_gap_a: assert property (tag_mode == RFT_POWER && !field_present
    && !nvm_cfg[LOCK_POS] |=> tag_mode == RFT_GAP) else $error("Gap not seen");
  gap_verify_a: assert property (tag_mode == RFT_GAP && field_present
    |=> tag_mode == RFT_VERIFY) else $error("Verify not entered");
  verify_len_a: assert property ($rose(tag_mode == RFT_PROG)
    && $past(tag_mode) == RFT_VERIFY |-> run_cnt >= 16'h3FFF && run_cnt <= 16'h4007)
    else $error("Verify length wrong");
  prog_len_a: assert property ($rose(nvm_wr_en)
    |-> tag_mode == RFT_RESP && run_cnt == 16'h3FFF) else $error("Program length wrong");
  wr_pulse_a: assert property (nvm_wr_en |=> !nvm_wr_en)
    else $error("Write strobe too long");
  lock_loss_a: assert property ((tag_mode == RFT_PROG || tag_mode == RFT_RESP)
    && !field_present |=> nvm_lock_set && tag_mode == RFT_DONE) else $error("No lock");
  done_hold_a: assert property (tag_mode == RFT_DONE |=> tag_mode == RFT_DONE)
    else $error("Left done mode");
  locked_boot_a: assert property ($fell(reset) && nvm_cfg[LOCK_POS]
    |=> tag_mode == RFT_READ) else $error("Locked tag not in read");
  read_hold_a: assert property (tag_mode == RFT_READ |=> tag_mode == RFT_READ)
    else $error("Read mode left");
  native_kind_a: assert property (!nvm_cfg[LOCK_POS] |=> mod_kind == 2'h0)
    else $error("Native kind wrong");
  read_kind_a: assert property (tag_mode == RFT_READ && $stable(nvm_cfg)
    |-> mod_kind == {nvm_cfg[MODK_HI], nvm_cfg[MODK_LO]}) else $error("Read kind wrong");
endmodule // rft_chk

bind rft_tag rft_chk chk_u (.sys_clk, .reset, .field_present, .nvm_cfg, .mod_kind,
  .nvm_wr_en, .nvm_lock_set, .tag_mode);

/* File: tb_top.sv */
module tb_top
  import rft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [MEM_BITS-1:0] PAT = 128'hC3A5_0F96_1E2D_4B78_0123_4567_89AB_CDE6;
  logic                sys_clk    = 1'b0;
  logic                reset      = 1'b1;
  logic                field_present;
  logic                field_high;
  logic [MEM_BITS-1:0] nvm_data;
  logic [CFG_BITS-1:0] nvm_cfg;
  logic                mod_out;
  logic [1:0]          mod_kind;
  logic                nvm_wr_en;
  logic [MEM_BITS-1:0] nvm_wr_data;
  logic                nvm_lock_set;
  rft_state_t          tag_mode;
  int                  error_cnt  = 0;
  int                  n_compared = 0;
  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #4 sys_clk = ~sys_clk;
  rft_tag dut_u (.sys_clk, .reset, .field_present, .field_high, .nvm_data, .nvm_cfg,
    .mod_out, .mod_kind, .nvm_wr_en, .nvm_wr_data, .nvm_lock_set, .tag_mode);
  rft_reader rd_u (.sys_clk, .nvm_wr_en, .nvm_wr_data, .nvm_lock_set, .field_present,
    .field_high, .nvm_data, .nvm_cfg);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  // Bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_mode(input rft_state_t m);
    int n;
    n = 0;
    while (tag_mode !== m && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    check(128'(tag_mode), 128'(m));
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Length of the second run of equal mod_out levels, bounded
  task automatic run_len(output int n);
    logic v;
    repeat (2) begin
      v = mod_out;
      n = 0;
      while (mod_out === v && n < 600) begin
        @(negedge sys_clk);
        n++;
      end
    end
  endtask
  task automatic t_native();
    int n;
    rd_u.nvm_data <= {64{2'b01}};
    do_reset();
    run_len(n);
    check(128'(n), 128'h80);
    check(128'(mod_kind), 128'h0);
    $display("native rate test done");
  endtask
  task automatic t_program();
    fork
      rd_u.send_bits(PAT);
    join_none
    wait_mode(RFT_VERIFY);
    repeat (8000) @(negedge sys_clk);
    check(128'(mod_out), 128'h1);
    wait_mode(RFT_PROG);
    wait_mode(RFT_RESP);
    check(128'(nvm_wr_en), 128'h1);
    check(nvm_wr_data, PAT);
    repeat (70) @(negedge sys_clk);
    check(128'(mod_out), 128'(PAT[0]));
    repeat (128) @(negedge sys_clk);
    check(128'(mod_out), 128'(PAT[1]));
    wait_mode(RFT_PROG);
    rd_u.drop();
    wait_mode(RFT_DONE);
    repeat (2) @(negedge sys_clk);
    check(128'(nvm_cfg[LOCK_POS]), 128'h1);
    $display("programming test done");
  endtask
  task automatic t_locked();
    int n;
    rd_u.gap();
    rd_u.nvm_cfg[MODK_HI] <= 1'b1;
    rd_u.nvm_cfg[RATE_LO:RATE_HI] <= 3'h7;
    do_reset();
    repeat (2) @(negedge sys_clk);
    check(128'(tag_mode), 128'(RFT_READ));
    check(128'(mod_kind), 128'h2);
    // Rate code seven, bits 1 and 2 of the word are ones: two 16-cycle bits
    run_len(n);
    check(128'(n), 128'h20);
    rd_u.gap();
    repeat (200) @(negedge sys_clk);
    check(128'(tag_mode), 128'(RFT_READ));
    $display("locked tag test done");
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_native();
    t_program();
    t_locked();
    stop_test();
  end
  // Hang guard, about twice the expected run
  initial begin
    #760000;
    error_cnt++;
    stop_test();
  end
endmodule // tb_top
